// >>> logic/fbrg_defines.svh
/*
  fbrg_defines.svh - register offsets, reset values, field positions and
  timing figures of the fractional baud rate generator.
  Assumes it is included by bare name by every design file that needs it.
*/
`ifndef FBRG_DEFINES_SVH
`define FBRG_DEFINES_SVH

// ============================================================
// register offsets on the internal register address A3:A0
// ============================================================
`define FBRG_OFS_DIV_LOW 4'h0
`define FBRG_OFS_DIV_HIGH 4'h1
`define FBRG_OFS_FRAC_MODE 4'h2
`define FBRG_OFS_MODEM_CTRL 4'h4
`define FBRG_OFS_STATUS 4'hF

// ============================================================
// reset values
// ============================================================
`define FBRG_RST_DIV_LOW 8'h01
`define FBRG_RST_DIV_HIGH 8'h00
`define FBRG_RST_FRAC_MODE 8'h00
`define FBRG_RST_PRESCALE 1'h0

// ============================================================
// field positions
// ============================================================
`define FBRG_MODEM_PRESCALE_BIT 7
`define FBRG_FRAC_MSB 3
`define FBRG_FRAC_LSB 0
`define FBRG_MODE_MSB 5
`define FBRG_MODE_LSB 4

// ============================================================
// sampling mode codes and bit lengths in sampling clocks
// ============================================================
`define FBRG_MODE_16X 2'h0
`define FBRG_MODE_8X 2'h1
`define FBRG_MODE_4X 2'h2
`define FBRG_BITLEN_16X 5'h10
`define FBRG_BITLEN_8X 5'h08
`define FBRG_BITLEN_4X 5'h04

// ============================================================
// prescaler and divisor limits
// ============================================================
`define FBRG_PRESCALE_LAST 2'h3
`define FBRG_DIV_MIN 16'h0001

// ============================================================
// timing
// ============================================================
`define FBRG_CLK_PERIOD_NS 10
`define FBRG_RESET_MIN_NS 40
`define FBRG_RESET_MIN_CYC ((`FBRG_RESET_MIN_NS + `FBRG_CLK_PERIOD_NS - 1) / `FBRG_CLK_PERIOD_NS)

`endif

// >>> logic/fbrg_pkg.sv
/*
  fbrg_pkg - types shared by the baud generator modules: the register
  request carrier, the divisor configuration and each module's state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fbrg_pkg;

  // ============================================================
  // register access request, same clock domain as the block
  // ============================================================
  typedef struct packed {
    logic wr;          // write strobe, one cycle
    logic rd;          // read strobe, one cycle
    logic [3:0] addr;  // register address A3:A0
    logic [7:0] wdata; // write data
  } fbrg_reg_req_t;

  // divisor handed to the fractional divider
  typedef struct packed {
    logic [15:0] whole; // integer part
    logic [3:0] frac;   // sixteenths
  } fbrg_div_cfg_t;

  // prescaler state
  typedef struct packed {
    logic [1:0] cnt;
    logic tick;
  } fbrg_pre_state_t;

  // fractional divider state
  typedef struct packed {
    logic [16:0] cnt;
    logic [3:0] acc;
    logic stretch;
    logic tick;
  } fbrg_div_state_t;

  // top level state
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] frac_mode;
    logic prescale;
    logic [4:0] bit_cnt;
    logic [7:0] rd_data;
    logic rd_valid;
    logic sample_tick;
    logic bit_tick;
    logic [1:0] mode;
    logic jitter;
  } fbrg_top_state_t;

endpackage

// >>> logic/fbrg_prescale.sv
/*
  fbrg_prescale - divides the input clock by 1 or 4 as an enable pulse.
  Assumes div4_in comes from a register on the same clock.
*/
`timescale 1ns/1ps
`include "fbrg_defines.svh"

module fbrg_prescale
(
  input wire logic clock_in, // input clock
  input wire logic rstn_in,  // async reset, active low
  input wire logic div4_in,  // high selects divide by 4
  output logic tick_out      // one-cycle enable per prescaled clock
);
  import fbrg_pkg::*;

  fbrg_pre_state_t st;      // registered state
  fbrg_pre_state_t next_st; // next state

  // ============================================================
  // next state
  // ============================================================
  always_comb
  begin
    next_st = st;
    if (!div4_in)
    begin
      // pass through: every clock is a prescaled clock
      next_st.tick = 1'b1;
      next_st.cnt = 2'h0;
    end
    else if (st.cnt == `FBRG_PRESCALE_LAST)
    begin
      next_st.tick = 1'b1;
      next_st.cnt = 2'h0;
    end
    else
    begin
      next_st.tick = 1'b0;
      next_st.cnt = st.cnt + 2'h1;
    end
  end

  // ============================================================
  // state register
  // ============================================================
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_out = st.tick;

endmodule

// >>> logic/fbrg_frac_div.sv
/*
  fbrg_frac_div - divides an enable stream by integer plus sixteenths,
  stretching chosen periods by one enable so the mean is exact.
  Assumes cfg_in is registered on the same clock.
*/
`timescale 1ns/1ps
`include "fbrg_defines.svh"

module fbrg_frac_div
(
  input wire logic clock_in,                  // input clock
  input wire logic rstn_in,                   // async reset, active low
  input wire logic en_in,                     // prescaled clock enable
  input wire fbrg_pkg::fbrg_div_cfg_t cfg_in, // divisor setting
  output logic tick_out                       // one-cycle sampling clock pulse
);
  import fbrg_pkg::*;

  fbrg_div_state_t st;      // registered state
  fbrg_div_state_t next_st; // next state
  logic [15:0] whole_eff;   // integer part, zero read as one
  logic [16:0] last;        // terminal count of this period
  logic [4:0] sum;          // fraction accumulator plus carry

  // ============================================================
  // next state: a carry out of the sixteenths adds one enable
  // ============================================================
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    // an integer of zero is outside the range, so it runs as one
    whole_eff = (cfg_in.whole == 16'h0000) ? `FBRG_DIV_MIN : cfg_in.whole;
    last = {1'b0, whole_eff} - 17'h00001 + {16'h0000, st.stretch};
    sum = {1'b0, st.acc} + {1'b0, cfg_in.frac};
    if (en_in)
    begin
      // >= keeps a shrunk divisor from wrapping the counter
      if (st.cnt >= last)
      begin
        next_st.tick = 1'b1;
        next_st.cnt = 17'h00000;
        next_st.acc = sum[3:0];
        next_st.stretch = sum[4];
      end
      else
        next_st.cnt = st.cnt + 17'h00001;
    end
  end

  // ============================================================
  // state register
  // ============================================================
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick_out = st.tick;

endmodule

// >>> logic/fbrg_baud_generator.sv
/*
  fbrg_baud_generator - per-UART fractional baud rate generator: holds the
  divisor, sampling mode and prescaler registers, produces the sampling
  clock pulse and the serial bit pulse for transmitter and receiver.
  Assumes clock_in is the crystal or external clock itself and that the
  register requests come from the host interface on the same clock.
*/
// How it works
// - prescaler divides input clock by 1 or 4
// - divisor from 1 to 65536 minus 1/16
// - own generator drives 16X/8X/4X sampling clock
// - reset divisor is one: 01, 00, 00
// - two bytes integer, four bits sixteenths
// - fraction bits 5:4 pick 16X, 8X, 4X
// - 8X odd fraction: bit jitter 1/16
// - 4X odd fraction: bit jitter 1/8
// - reset pulse over 40 ns restores defaults
// - accepts input clock up to 64 MHz
// - one bit lasts 16, 8, 4 samples
`timescale 1ns/1ps
`include "fbrg_defines.svh"

module fbrg_baud_generator
(
  input wire logic clock_in,                  // crystal or external clock
  input wire logic rstn_in,                   // async reset, active low
  input wire fbrg_pkg::fbrg_reg_req_t req_in, // register read/write request
  output logic [7:0] rd_data_out,             // read data
  output logic rd_valid_out,                  // read data valid pulse
  output logic sample_tick_out,               // sampling clock pulse
  output logic bit_tick_out,                  // end of one serial bit pulse
  output logic [1:0] sample_mode_out,         // active sampling mode
  output logic jitter_flag_out                // bit time jitter expected
);
  import fbrg_pkg::*;

  fbrg_top_state_t st;      // registered state
  fbrg_top_state_t next_st; // next state
  fbrg_div_cfg_t div_cfg;   // divisor to the divider
  logic pre_tick;           // prescaled clock enable
  logic div_tick;           // sampling clock from the divider
  logic [4:0] bit_len;      // samples per bit in the active mode
  logic [1:0] mode_sel;     // decoded mode field of the register
  logic [15:0] whole_eff;   // integer part as the divider runs it

  // ============================================================
  // prescaler and fractional divider
  // ============================================================
  // the prescaler runs straight off the input clock, so its rate limit
  // is the clock limit of this block
  fbrg_prescale u_prescale
  (
    .clock_in (clock_in),
    .rstn_in (rstn_in),
    .div4_in (st.prescale),
    .tick_out (pre_tick)
  );

  // integer from the two bytes, sixteenths from the low nibble
  assign div_cfg.whole = {st.div_high, st.div_low};
  assign div_cfg.frac = st.frac_mode[`FBRG_FRAC_MSB:`FBRG_FRAC_LSB];
  assign whole_eff = (div_cfg.whole == 16'h0000) ? `FBRG_DIV_MIN : div_cfg.whole;

  fbrg_frac_div u_frac_div
  (
    .clock_in (clock_in),
    .rstn_in (rstn_in),
    .en_in (pre_tick),
    .cfg_in (div_cfg),
    .tick_out (div_tick)
  );

  // ============================================================
  // mode decode
  // ============================================================
  always_comb
  begin
    mode_sel = st.frac_mode[`FBRG_MODE_MSB:`FBRG_MODE_LSB];
    unique case (st.mode)
      `FBRG_MODE_8X: bit_len = `FBRG_BITLEN_8X;
      `FBRG_MODE_4X: bit_len = `FBRG_BITLEN_4X;
      default: bit_len = `FBRG_BITLEN_16X;
    endcase
  end

  // ============================================================
  // next state: registers, bit counter, status
  // ============================================================
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.bit_tick = 1'b0;
    // one pulse per divider period is the sampling clock
    next_st.sample_tick = div_tick;
    // register writes
    if (req_in.wr)
    begin
      case (req_in.addr)
        `FBRG_OFS_DIV_LOW: next_st.div_low = req_in.wdata;
        `FBRG_OFS_DIV_HIGH: next_st.div_high = req_in.wdata;
        `FBRG_OFS_FRAC_MODE: next_st.frac_mode = req_in.wdata;
        `FBRG_OFS_MODEM_CTRL: next_st.prescale = req_in.wdata[`FBRG_MODEM_PRESCALE_BIT];
        default: next_st.prescale = st.prescale; // unmapped or read-only
      endcase
    end
    // register reads, answered one cycle later
    if (req_in.rd)
    begin
      next_st.rd_valid = 1'b1;
      case (req_in.addr)
        `FBRG_OFS_DIV_LOW: next_st.rd_data = st.div_low;
        `FBRG_OFS_DIV_HIGH: next_st.rd_data = st.div_high;
        `FBRG_OFS_FRAC_MODE: next_st.rd_data = st.frac_mode;
        `FBRG_OFS_MODEM_CTRL: next_st.rd_data = {st.prescale, 7'h00};
        `FBRG_OFS_STATUS: next_st.rd_data = {5'h00, st.jitter, st.mode};
        default: next_st.rd_data = 8'h00; // unmapped reads as zero
      endcase
    end
    // code 11 is not a mode; it runs as 16X rather than stopping
    unique case (mode_sel)
      `FBRG_MODE_8X: next_st.mode = `FBRG_MODE_8X;
      `FBRG_MODE_4X: next_st.mode = `FBRG_MODE_4X;
      default: next_st.mode = `FBRG_MODE_16X;
    endcase
    // odd sixteenths cannot split evenly over 8 or 4 samples per bit
    next_st.jitter = div_cfg.frac[0] &&
                     ((mode_sel == `FBRG_MODE_8X) || (mode_sel == `FBRG_MODE_4X));
    // bit counter; the fraction accumulator is not reset per bit, which
    // keeps the mean rate exact at the cost of the jitter above
    if (div_tick)
    begin
      if (st.bit_cnt >= bit_len - 5'h01)
      begin
        next_st.bit_tick = 1'b1;
        next_st.bit_cnt = 5'h00;
      end
      else
        next_st.bit_cnt = st.bit_cnt + 5'h01;
    end
  end

  // ============================================================
  // state register; the async reset restores every default at once,
  // so any low pulse, certainly one over 40 ns, takes effect
  // ============================================================
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st <= '0;
      st.div_low <= `FBRG_RST_DIV_LOW;
      st.div_high <= `FBRG_RST_DIV_HIGH;
      st.frac_mode <= `FBRG_RST_FRAC_MODE;
      st.prescale <= `FBRG_RST_PRESCALE;
    end
    else
      st <= next_st;
  end

  assign rd_data_out = st.rd_data;
  assign rd_valid_out = st.rd_valid;
  assign sample_tick_out = st.sample_tick;
  assign bit_tick_out = st.bit_tick;
  assign sample_mode_out = st.mode;
  assign jitter_flag_out = st.jitter;

  // ============================================================
  // checking helpers: enables per period, samples per bit
  // ============================================================
  logic [16:0] h_en_cnt; // prescaled enables since last sampling pulse
  logic [1:0] h_div_dirty; // periods a divisor write may disturb
  logic [4:0] h_smp_cnt; // sampling pulses since last bit pulse
  logic h_mode_dirty;    // mode written during this bit

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      h_en_cnt <= 17'h00000;
      h_div_dirty <= 2'h0;
      h_smp_cnt <= 5'h00;
      h_mode_dirty <= 1'b0;
    end
    else
    begin
      h_en_cnt <= div_tick ? {16'h0000, pre_tick} : h_en_cnt + {16'h0000, pre_tick};
      // a write marks its own period and the next one, whose stretch
      // was decided with the old fraction
      if (req_in.wr && (req_in.addr <= `FBRG_OFS_FRAC_MODE))
        h_div_dirty <= 2'h2;
      else if (div_tick && (h_div_dirty != 2'h0))
        h_div_dirty <= h_div_dirty - 2'h1;
      h_smp_cnt <= st.bit_tick ? 5'h00 : h_smp_cnt + {4'h0, st.sample_tick};
      if (req_in.wr && (req_in.addr == `FBRG_OFS_FRAC_MODE))
        h_mode_dirty <= 1'b1;
      else if (st.bit_tick)
        h_mode_dirty <= 1'b0;
    end
  end

  // ============================================================
  // assertions
  // ============================================================
  AST_PRESCALE_BY1: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!st.prescale)[*2] |-> pre_tick)
    else $error("prescaler skipped a clock while dividing by one");

  AST_PRESCALE_BY4: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st.prescale[*6] ##0 pre_tick |-> $past(pre_tick, 4) && !$past(pre_tick, 1))
    else $error("prescaler period is not four clocks");

  AST_INT_PERIOD: assert property (@(posedge clock_in) disable iff (!rstn_in)
    div_tick && (h_div_dirty == 2'h0) && (div_cfg.frac == 4'h0) |-> h_en_cnt == {1'b0, whole_eff})
    else $error("integer divisor period wrong");

  AST_FRAC_PERIOD: assert property (@(posedge clock_in) disable iff (!rstn_in)
    div_tick && (h_div_dirty == 2'h0) && (div_cfg.frac != 4'h0) |->
      (h_en_cnt == {1'b0, whole_eff}) || (h_en_cnt == {1'b0, whole_eff} + 17'h00001))
    else $error("fractional period is not integer or integer plus one");

  AST_BIT_LENGTH: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st.bit_tick && !h_mode_dirty |-> (h_smp_cnt + 5'h01) == bit_len)
    else $error("bit does not last the mode's sample count");

  AST_BIT_ON_SAMPLE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    st.bit_tick |-> st.sample_tick)
    else $error("bit pulse without a sampling pulse");

  AST_RESET_DEFAULTS: assert property (@(posedge clock_in)
    $rose(rstn_in) |-> (st.div_low == `FBRG_RST_DIV_LOW) && (st.div_high == `FBRG_RST_DIV_HIGH)
      && (st.frac_mode == `FBRG_RST_FRAC_MODE) && !st.prescale)
    else $error("divisor defaults wrong after reset");

  AST_MODE_DECODE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h1)[*2] |-> sample_mode_out == `FBRG_MODE_8X ##0 bit_len == `FBRG_BITLEN_8X)
    else $error("mode field 01 did not select 8X");

  AST_JITTER_8X: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h1 && st.frac_mode[0])[*2] |-> jitter_flag_out)
    else $error("8X odd fraction not flagged");

  AST_JITTER_4X: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h2)[*2] ##0 (st.frac_mode[1:0] == 2'h0) |-> !jitter_flag_out)
    else $error("4X fraction multiple of four flagged");

  AST_READ_LOW: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.rd && (req_in.addr == `FBRG_OFS_DIV_LOW) |=> rd_valid_out && (rd_data_out == $past(st.div_low)))
    else $error("low divisor byte read back wrong");

  // a read answers one cycle late
  // with the value held before it
  AST_READ_HIGH: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.rd && (req_in.addr == `FBRG_OFS_DIV_HIGH) |=> rd_data_out == $past(st.div_high))
    else $error("high byte read wrong");

  AST_READ_FRAC: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.rd && (req_in.addr == `FBRG_OFS_FRAC_MODE) |=> rd_data_out == $past(st.frac_mode))
    else $error("fraction read wrong");

  // status mirrors the outputs
  AST_READ_STATUS: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.rd && (req_in.addr == `FBRG_OFS_STATUS) |=> rd_data_out == {5'h00, $past(st.jitter), $past(st.mode)})
    else $error("status read wrong");

  // a write lands at its own edge
  // so the next read sees it
  AST_WRITE_LOW: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.wr && (req_in.addr == `FBRG_OFS_DIV_LOW) |=> st.div_low == $past(req_in.wdata))
    else $error("low byte write lost");

  // modem control keeps one bit
  AST_WRITE_PRESCALE: assert property (@(posedge clock_in) disable iff (!rstn_in)
    req_in.wr && (req_in.addr == `FBRG_OFS_MODEM_CTRL) |=> st.prescale == $past(req_in.wdata[7]))
    else $error("prescale write lost");

  // field to mode takes one edge
  AST_MODE_4X: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h2)[*2] |-> sample_mode_out == `FBRG_MODE_4X)
    else $error("field 10 did not select 4X");

  // odd sixteenths cannot split over 4
  AST_JITTER_4X_ODD: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h2 && st.frac_mode[0])[*2] |-> jitter_flag_out)
    else $error("4X odd fraction not flagged");

  // 16 samples absorb any fraction
  // so the flag stays low at 16X
  AST_NO_JITTER_16X: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (st.frac_mode[5:4] == 2'h0)[*2] |-> !jitter_flag_out)
    else $error("16X flagged as jitter");

  // the output is one register behind
  // the divider, nothing else gates it
  AST_SAMPLE_FOLLOWS_DIV: assert property (@(posedge clock_in) disable iff (!rstn_in)
    div_tick |=> sample_tick_out)
    else $error("divider pulse lost");

endmodule

// >>> tb/fbrg_uart_timing_model.sv
/*
  fbrg_uart_timing_model - stands in for the transmitter and receiver bit
  timing logic: counts sampling pulses per serial bit.
  Assumes both pulses are one cycle wide on clock_in.
*/
`timescale 1ns/1ps

module fbrg_uart_timing_model
(
  input wire logic clock_in,       // block clock
  input wire logic rstn_in,        // async reset, active low
  input wire logic sample_tick_in, // sampling clock pulse
  input wire logic bit_tick_in,    // end of bit pulse
  output logic [7:0] bit_len_out,  // sampling pulses in last bit
  output logic [15:0] bit_seen_out // bits completed
);
  logic [7:0] samp_cnt; // pulses since last bit end

  // ============================================================
  // bit framing as the shifter sees it
  // ============================================================
  // a bit end shares its cycle with a sampling pulse, so count it in
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      samp_cnt <= 8'h00;
      bit_len_out <= 8'h00;
      bit_seen_out <= 16'h0000;
    end
    else if (bit_tick_in)
    begin
      bit_len_out <= samp_cnt + {7'h00, sample_tick_in};
      samp_cnt <= 8'h00;
      bit_seen_out <= bit_seen_out + 16'h0001;
    end
    else if (sample_tick_in)
    begin
      samp_cnt <= samp_cnt + 8'h01;
    end
  end
endmodule

// >>> tb/fbrg_baud_generator_tb.sv
/*
  fbrg_baud_generator_tb - self-checking bench for the baud generator.
  Assumes the register offsets of fbrg_defines.svh; inputs move on falling edges.
*/
`timescale 1ns/1ps
`include "fbrg_defines.svh"

module fbrg_baud_generator_tb;
  import fbrg_pkg::*;

  logic clock_in; // 100 MHz clock
  logic rstn_in; // reset, active low
  fbrg_reg_req_t req; // register request
  logic [7:0] rd_data; // read data
  logic rd_valid; // read valid
  logic sample_tick; // sampling pulse
  logic bit_tick; // bit end pulse
  logic [1:0] sample_mode; // active mode
  logic jitter_flag; // jitter flag
  logic [7:0] bit_len; // model: pulses per bit
  logic [15:0] bit_seen; // model: bits done
  int n_mismatch = 0; // mismatches
  int checks_done = 0; // comparisons
  int cyc = 0; // cycle count for the hang guard

  fbrg_baud_generator uut (.clock_in(clock_in), .rstn_in(rstn_in), .req_in(req), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .sample_tick_out(sample_tick), .bit_tick_out(bit_tick),
    .sample_mode_out(sample_mode), .jitter_flag_out(jitter_flag));
  fbrg_uart_timing_model far (.clock_in(clock_in), .rstn_in(rstn_in), .sample_tick_in(sample_tick),
    .bit_tick_in(bit_tick), .bit_len_out(bit_len), .bit_seen_out(bit_seen));

  // ============================================================
  // clock and hang guard
  // ============================================================
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // the longest test needs well under 10000 cycles
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // ============================================================
  // shared tasks
  // ============================================================
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock_in);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock_in);
    req.wr = 1'b0;
  endtask

  // read strobe lasts one cycle; the valid pulse is awaited for a few cycles
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    int i;
    @(negedge clock_in);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_in);
    req.rd = 1'b0;
    d = 8'hXX;
    for (i = 0; i < 4; i++)
    begin
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        break;
      end
      @(negedge clock_in);
    end
  endtask

  task automatic read_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check("register read", {24'h0, exp}, {24'h0, d});
  endtask

  // clocks spanned by k sampling pulses, starting at a pulse
  task automatic measure(input int k, output int clocks);
    int t;
    clocks = 0;
    t = 0;
    while (sample_tick !== 1'b1 && clocks < 2000)
    begin
      @(negedge clock_in);
      clocks++;
    end
    clocks = 0;
    while (t < k && clocks < 6000)
    begin
      @(negedge clock_in);
      clocks++;
      if (sample_tick === 1'b1)
        t++;
    end
  endtask

  task automatic set_div(input logic [15:0] n, input logic [7:0] fm);
    int c;
    reg_write(`FBRG_OFS_DIV_LOW, n[7:0]);
    reg_write(`FBRG_OFS_DIV_HIGH, n[15:8]);
    reg_write(`FBRG_OFS_FRAC_MODE, fm);
    measure(2, c);
  endtask

  // ============================================================
  // scenarios
  // ============================================================
  task automatic t_reset_values();
    read_check(`FBRG_OFS_DIV_LOW, `FBRG_RST_DIV_LOW);
    read_check(`FBRG_OFS_DIV_HIGH, `FBRG_RST_DIV_HIGH);
    read_check(`FBRG_OFS_FRAC_MODE, `FBRG_RST_FRAC_MODE);
    read_check(`FBRG_OFS_MODEM_CTRL, 8'h00);
    read_check(4'h7, 8'h00);
  endtask

  task automatic t_readback();
    reg_write(`FBRG_OFS_DIV_LOW, 8'h5A);
    reg_write(`FBRG_OFS_DIV_HIGH, 8'h3C);
    reg_write(`FBRG_OFS_FRAC_MODE, 8'h25);
    reg_write(`FBRG_OFS_MODEM_CTRL, 8'hFF);
    reg_write(`FBRG_OFS_STATUS, 8'hFF);
    read_check(`FBRG_OFS_DIV_LOW, 8'h5A);
    read_check(`FBRG_OFS_DIV_HIGH, 8'h3C);
    read_check(`FBRG_OFS_FRAC_MODE, 8'h25);
    read_check(`FBRG_OFS_MODEM_CTRL, 8'h80);
    read_check(`FBRG_OFS_STATUS, 8'h06);
    reg_write(`FBRG_OFS_MODEM_CTRL, 8'h00);
  endtask

  // integer divisors, the high byte included
  task automatic t_integer();
    int c;
    logic [15:0] n[4] = '{16'h0001, 16'h0003, 16'h0007, 16'h0100};
    foreach (n[i])
    begin
      set_div(n[i], 8'h00);
      measure(2, c);
      check("integer period", 2 * n[i], c);
    end
  endtask

  task automatic t_prescale();
    int c;
    set_div(16'h0002, 8'h00);
    reg_write(`FBRG_OFS_MODEM_CTRL, 8'h80);
    measure(2, c);
    measure(4, c);
    check("prescaled period", 32, c);
    reg_write(`FBRG_OFS_MODEM_CTRL, 8'h00);
  endtask

  // sixteen periods always carry exactly frac extra clocks
  task automatic t_fraction();
    int c;
    logic [3:0] f[3] = '{4'h1, 4'h8, 4'hF};
    foreach (f[i])
    begin
      set_div(16'h0003, {4'h0, f[i]});
      measure(16, c);
      check("fractional period", 48 + f[i], c);
    end
  endtask

  task automatic t_modes();
    int i;
    logic [15:0] s;
    logic [4:0] len[4] = '{`FBRG_BITLEN_16X, `FBRG_BITLEN_8X, `FBRG_BITLEN_4X, `FBRG_BITLEN_16X};
    logic [1:0] md[4] = '{`FBRG_MODE_16X, `FBRG_MODE_8X, `FBRG_MODE_4X, `FBRG_MODE_16X};
    for (i = 0; i < 4; i++)
    begin
      set_div(16'h0001, {2'h0, i[1:0], 4'h0});
      s = bit_seen;
      while (bit_seen - s < 16'h0002 && cyc < 39000)
        @(negedge clock_in);
      check("bit length", {27'h0, len[i]}, {24'h0, bit_len});
      check("sample mode", {30'h0, md[i]}, {30'h0, sample_mode});
    end
  endtask

  task automatic t_jitter();
    logic [7:0] fm[5] = '{8'h13, 8'h14, 8'h25, 8'h22, 8'h03};
    logic exp[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    foreach (fm[i])
    begin
      set_div(16'h0002, fm[i]);
      check("jitter flag", {31'h0, exp[i]}, {31'h0, jitter_flag});
    end
  endtask

  // reset in mid-run, 50 ns wide
  task automatic t_reset_mid();
    set_div(16'h0109, 8'h17);
    @(negedge clock_in);
    rstn_in = 1'b0;
    repeat (5) @(negedge clock_in);
    check("tick in reset", 0, {31'h0, sample_tick});
    check("mode in reset", 0, {30'h0, sample_mode});
    rstn_in = 1'b1;
    t_reset_values();
  endtask

  // ============================================================
  // main sequence
  // ============================================================
  initial
  begin
    rstn_in = 1'b0;
    req = '0;
    repeat (16) @(negedge clock_in);
    rstn_in = 1'b1;
    t_reset_values();
    t_readback();
    t_integer();
    t_prescale();
    t_fraction();
    t_modes();
    t_jitter();
    t_reset_mid();
    complete_run();
  end
endmodule
